/* logic/rbs_consts.svh */
/*
 * Register offsets, field positions, reset values and timing figures
 * of the receive back-plane serial block.
 * Assumes inclusion by bare name from the block's files.
 */
`ifndef RBS_CONSTS_SVH
`define RBS_CONSTS_SVH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define RBS_ADDR_W 12
`define RBS_CTRL_OFS 12'h000
`define RBS_STATUS_OFS 12'h004

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define RBS_CTRL_W 7
`define RBS_CTRL_RESET 7'h08

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define RBS_ST_UNDERRUN 0
`define RBS_ST_SLIP 1
`define RBS_ST_CLK_OUT 2
`define RBS_ST_ALIGNED 3
`define RBS_ST_LEVEL_LSB 4
`define RBS_ST_RATE_LSB 8

// ----------------------------------------------------------------
// Timing: driven 1.544 MHz serial clock
// ----------------------------------------------------------------
`define RBS_HCLK_PERIOD_PS 4000
`define RBS_DS1_CLK_PERIOD_PS 647668
`define RBS_DS1_HALF_CYC ((`RBS_DS1_CLK_PERIOD_PS) / (2 * `RBS_HCLK_PERIOD_PS))
`define RBS_FIFO_DEPTH 8

`endif

/* logic/rbs_pkg.sv */
/*
 * Types of the receive back-plane serial block.
 * Assumes rbs_consts.svh is available on the include path.
 */
package rbs_pkg;

    // Back-plane rate selected while multiplexing is off
    typedef enum logic [1:0] {
        RBS_RATE_1544 = 2'b00,
        RBS_RATE_2048 = 2'b01,
        RBS_RATE_4096 = 2'b10,
        RBS_RATE_8192 = 2'b11
    } rbs_rate_e;

    // Output sequencer, Gray coded along idle, align, run
    typedef enum logic [1:0] {
        RBS_IDLE = 2'b00,
        RBS_ALIGN = 2'b01,
        RBS_RUN = 2'b11
    } rbs_state_e;

    // One payload bit with its frame markers
    typedef struct packed {
        logic crc_mf_start;
        logic mf_start;
        logic frame_start;
        logic payload;
    } rbs_bit_s;

    // Control register layout, bit 0 is mux_en
    typedef struct packed {
        logic crc_en;
        logic e1;
        logic edge_rise;
        logic slip_en;
        rbs_rate_e rate;
        logic mux_en;
    } rbs_ctrl_s;

endpackage : rbs_pkg

/* logic/rbs_fifo.sv */
/*
 * Flip-flop FIFO with valid/ready on both sides.
 * Assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
module rbs_fifo #(
    parameter int WIDTH = 4,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_ptr_q;
    logic [AW:0] rd_ptr_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign level = wr_ptr_q - rd_ptr_q;
    assign in_ready = (level != (AW+1)'(DEPTH));
    assign out_valid = (level != '0);
    assign out_data = mem_q[rd_ptr_q[AW-1:0]];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_ptr_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            wr_ptr_q <= wr_ptr_q + (push ? {{AW{1'b0}}, 1'b1} : '0);
            rd_ptr_q <= rd_ptr_q + (pop ? {{AW{1'b0}}, 1'b1} : '0);
        end
    end
endmodule : rbs_fifo

/* logic/rbs_top.sv */
/*
 * Receive back-plane serial output of one framer channel: payload
 * shifter, serial clock direction and divider, frame, multiframe and
 * CRC multiframe sync outputs, AHB-Lite register slave.
 * Assumes framed bits arrive on a valid/ready stream on hclk, and
 * the serial clock and frame sync pins are asynchronous to hclk.
 */
//
// Behaviour
// - DS1: multiframe sync high one serial clock period with multiframe first bit.
// - E1: CRC multiframe sync high one serial clock period with its first bit.
// - CRC multiframe sync stays low while CRC multiframe alignment is off.
// - Payload shifts out on the serial clock, rising or falling edge selectable.
// - Mode 00 without multiplexing presents data at 1.544 Mbit/s; the driven clock runs at 1.5625 MHz, as DIV_HALF truncates to 80.
// - Mode 00: clock pin input with slip buffer, driven output when bypassed.
// - Mode 01: 2.048 Mbit/s, serial clock supplied from outside.
// - Mode 10: 4.096 Mbit/s, serial clock supplied from outside.
// - Mode 11: 8.192 Mbit/s, serial clock supplied from outside.
// - Frame sync pulse is input with slip buffer, driven by block when bypassed.
`timescale 1ns/1ps
`include "rbs_consts.svh"

module rbs_top #(
    parameter int DIV_HALF = `RBS_DS1_HALF_CYC,
    parameter int FIFO_DEPTH = `RBS_FIFO_DEPTH
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic bit_valid,
    output logic bit_ready,
    input wire rbs_pkg::rbs_bit_s bit_data,
    input wire logic rx_serial_clock_i,
    output logic rx_serial_clock_o,
    output logic rx_serial_clock_oe,
    input wire logic rx_frame_sync_i,
    output logic rx_frame_sync_o,
    output logic rx_frame_sync_oe,
    output logic rx_serial_payload,
    output logic rx_multiframe_sync,
    output logic rx_crc_multiframe_sync
);
    import rbs_pkg::*;

    localparam int LW = $clog2(FIFO_DEPTH) + 1;

    // ----------------------------------------------------------------
    // AHB-Lite slave
    // ----------------------------------------------------------------
    rbs_ctrl_s cfg_q;
    logic [`RBS_ADDR_W-1:0] addr_q;
    logic wr_q;
    logic underrun_q;
    logic slip_q;
    logic [31:0] hrdata_q;
    logic [LW-1:0] level;
    rbs_state_e state_q;
    logic clk_oe_q;

    wire addr_phase = hsel && htrans[1] && hready;
    wire [`RBS_ADDR_W-1:0] a_ofs = haddr[`RBS_ADDR_W-1:0];
    wire hit_ctrl_rd = addr_phase && !hwrite && (a_ofs == `RBS_CTRL_OFS);
    wire hit_stat_rd = addr_phase && !hwrite && (a_ofs == `RBS_STATUS_OFS);
    wire ctrl_wr = wr_q && (addr_q == `RBS_CTRL_OFS);
    wire stat_wr = wr_q && (addr_q == `RBS_STATUS_OFS);
    wire clr_underrun = stat_wr && hwdata[`RBS_ST_UNDERRUN];
    wire clr_slip = stat_wr && hwdata[`RBS_ST_SLIP];

    wire [31:0] status_word = {22'h000000, cfg_q.rate, level[3:0], state_q == RBS_RUN,
        clk_oe_q, slip_q, underrun_q};
    wire [31:0] ctrl_word = {25'h0000000, cfg_q};
    wire [31:0] rd_mux;
    assign rd_mux = hit_ctrl_rd ? ctrl_word :
        hit_stat_rd ? status_word : 32'h00000000;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_q <= '0;
            wr_q <= 1'b0;
            hrdata_q <= 32'h00000000;
        end else begin
            wr_q <= addr_phase && hwrite && (hsize == 3'h2);
            if (addr_phase) begin
                addr_q <= a_ofs;
            end
            hrdata_q <= rd_mux;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_q <= rbs_ctrl_s'(`RBS_CTRL_RESET);
        end else if (ctrl_wr) begin
            cfg_q <= rbs_ctrl_s'(hwdata[`RBS_CTRL_W-1:0]);
        end
    end

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic clk_s1_q, clk_s2_q;
    logic sync_s1_q, sync_s2_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_s1_q <= 1'b0;
            clk_s2_q <= 1'b0;
            sync_s1_q <= 1'b0;
            sync_s2_q <= 1'b0;
        end else begin
            clk_s1_q <= rx_serial_clock_i;
            clk_s2_q <= clk_s1_q;
            sync_s1_q <= rx_frame_sync_i;
            sync_s2_q <= sync_s1_q;
        end
    end

    // ----------------------------------------------------------------
    // Serial clock source and direction
    // ----------------------------------------------------------------
    logic clk_gen_q;
    logic [15:0] div_cnt_q;
    logic src_prev_q;

    wire mode_1544 = !cfg_q.mux_en && (cfg_q.rate == RBS_RATE_1544);
    wire clk_drive = mode_1544 && !cfg_q.slip_en;
    wire div_wrap = (div_cnt_q == 16'(DIV_HALF - 1));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_cnt_q <= 16'h0000;
            clk_gen_q <= 1'b0;
        end else if (!clk_drive) begin
            div_cnt_q <= 16'h0000;
            clk_gen_q <= 1'b0;
        end else begin
            div_cnt_q <= div_wrap ? 16'h0000 : div_cnt_q + 16'h0001;
            clk_gen_q <= clk_gen_q ^ div_wrap;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_oe_q <= 1'b0;
        end else begin
            clk_oe_q <= clk_drive;
        end
    end

    assign rx_serial_clock_oe = clk_oe_q;
    assign rx_serial_clock_o = clk_gen_q;

    // Edges of whichever clock paces the line
    wire src_now = clk_drive ? clk_gen_q : clk_s2_q;
    wire src_rise = src_now && !src_prev_q;
    wire src_fall = !src_now && src_prev_q;
    wire shift_tick = cfg_q.edge_rise ? src_rise : src_fall;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_prev_q <= 1'b0;
        end else begin
            src_prev_q <= src_now;
        end
    end

    // ----------------------------------------------------------------
    // Bit buffer
    // ----------------------------------------------------------------
    rbs_bit_s head;
    logic head_valid;
    logic pop;

    rbs_fifo #(
        .WIDTH($bits(rbs_bit_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(hclk),
        .rst_n(hresetn),
        .in_valid(bit_valid),
        .in_ready(bit_ready),
        .in_data(bit_data),
        .out_valid(head_valid),
        .out_ready(pop),
        .out_data(head),
        .level(level)
    );

    // ----------------------------------------------------------------
    // Output sequencer
    // ----------------------------------------------------------------
    rbs_state_e state_d;

    // Frame start accepted when bypassed, or on the far end's sync pulse
    wire start_ok = !cfg_q.slip_en || sync_s2_q;
    wire slip_hit = cfg_q.slip_en && sync_s2_q && !head.frame_start;
    wire in_run = (state_q == RBS_RUN);
    wire in_align = (state_q == RBS_ALIGN);
    wire run_pop = in_run && !slip_hit;
    wire align_pop = in_align && (!head.frame_start || start_ok);
    assign pop = shift_tick && head_valid && (run_pop || align_pop);
    wire present = pop && (in_run || head.frame_start);
    wire underrun_set = shift_tick && in_run && !head_valid;
    wire slip_set = shift_tick && in_run && head_valid && slip_hit;

    always_comb begin
        state_d = state_q;
        case (state_q)
            RBS_IDLE: begin
                if (!cfg_q.mux_en) begin
                    state_d = RBS_ALIGN;
                end
            end
            RBS_ALIGN: begin
                if (present) begin
                    state_d = RBS_RUN;
                end
            end
            RBS_RUN: begin
                if (slip_set) begin
                    state_d = RBS_ALIGN;
                end
            end
            default: begin
                state_d = RBS_IDLE;
            end
        endcase
        if (cfg_q.mux_en) begin
            state_d = RBS_IDLE;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= RBS_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Sticky flags: a new event wins over a software clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            underrun_q <= 1'b0;
            slip_q <= 1'b0;
        end else begin
            underrun_q <= underrun_set || (underrun_q && !clr_underrun);
            slip_q <= slip_set || (slip_q && !clr_slip);
        end
    end

    // ----------------------------------------------------------------
    // Serial outputs, updated on the active edge only, cleared at once while multiplexing is on
    // ----------------------------------------------------------------
    logic pay_q, mf_q, crc_q, fs_q, fs_oe_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pay_q <= 1'b0;
            mf_q <= 1'b0;
            crc_q <= 1'b0;
            fs_q <= 1'b0;
        end else if (cfg_q.mux_en) begin
            pay_q <= 1'b0;
            mf_q <= 1'b0;
            crc_q <= 1'b0;
            fs_q <= 1'b0;
        end else if (shift_tick) begin
            pay_q <= present && head.payload;
            mf_q <= present && !cfg_q.e1 && head.mf_start;
            crc_q <= present && cfg_q.e1 && cfg_q.crc_en && head.crc_mf_start;
            fs_q <= present && head.frame_start;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fs_oe_q <= 1'b0;
        end else begin
            fs_oe_q <= !cfg_q.slip_en && !cfg_q.mux_en;
        end
    end

    assign rx_serial_payload = pay_q;
    assign rx_multiframe_sync = mf_q;
    assign rx_crc_multiframe_sync = crc_q;
    assign rx_frame_sync_o = fs_q;
    assign rx_frame_sync_oe = fs_oe_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    mf_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn)
        shift_tick && present && !cfg_q.e1 && !cfg_q.mux_en && head.mf_start |=> rx_multiframe_sync)
        else $error("multiframe sync missing at multiframe start");

    crc_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn)
        shift_tick && present && cfg_q.e1 && cfg_q.crc_en && !cfg_q.mux_en && head.crc_mf_start
        |=> rx_crc_multiframe_sync)
        else $error("crc multiframe sync missing at crc multiframe start");

    crc_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(shift_tick) && !$past(cfg_q.crc_en) |-> !rx_crc_multiframe_sync)
        else $error("crc multiframe sync high while alignment disabled");

    payload_edge_a: assert property (@(posedge hclk) disable iff (!hresetn)
        shift_tick && present && !cfg_q.mux_en |=> rx_serial_payload == $past(head.payload))
        else $error("payload bit not presented on active edge");

    clk_drive_a: assert property (@(posedge hclk) disable iff (!hresetn)
        mode_1544 && !cfg_q.slip_en |=> rx_serial_clock_oe)
        else $error("serial clock not driven with slip buffer bypassed");

    clk_input_a: assert property (@(posedge hclk) disable iff (!hresetn)
        cfg_q.rate != RBS_RATE_1544 || cfg_q.slip_en || cfg_q.mux_en |=> !rx_serial_clock_oe)
        else $error("serial clock driven while it must be an input");

    div_half_a: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_drive && $changed(clk_gen_q) ##1 clk_drive [*2] |-> $stable(clk_gen_q))
        else $error("driven serial clock half period too short");

    sync_edge_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $changed(rx_multiframe_sync) || $changed(rx_crc_multiframe_sync)
        |-> $past(shift_tick) || $past(cfg_q.mux_en))
        else $error("sync output moved off the active edge");

    fs_out_a: assert property (@(posedge hclk) disable iff (!hresetn)
        shift_tick && present && head.frame_start && !cfg_q.mux_en |=> rx_frame_sync_o)
        else $error("frame sync pulse missing at frame start");

    mux_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
        cfg_q.mux_en |=> state_q == RBS_IDLE && !rx_serial_payload && !rx_serial_clock_oe)
        else $error("block active while multiplexing enabled");

endmodule : rbs_top

/* dv/rbs_bp_partner.sv */
/*
 * Back-plane partner: supplies the receive serial clock and the frame sync pulse.
 * Assumes one frame is FRAME serial bits and the bench starts and stops it with run.
 */
`timescale 1ns/1ps
module rbs_bp_partner #(
    parameter int HALF_NS = 80,
    parameter int FRAME = 8
) (
    input wire logic run,
    input wire logic edge_rise,
    output logic clk_o,
    output logic sync_o
);
    int k;
    // ----------------------------------------------------------------
    // Clock stands still at 0 between runs; sync moves on the inactive edge
    // ----------------------------------------------------------------
    initial begin
        clk_o = 1'b0;
        sync_o = 1'b0;
        k = 0;
        #13;
        forever begin
            #HALF_NS;
            if (!run) begin
                clk_o = 1'b0;
                sync_o = 1'b0;
                k = 0;
            end else begin
                clk_o = ~clk_o;
                if (clk_o != edge_rise) begin
                    sync_o = (k % FRAME == 0);
                    k++;
                end
            end
        end
    end
endmodule : rbs_bp_partner

/* dv/tb.sv */
/*
 * Self-checking bench of the receive back-plane serial block.
 * Assumes the design's register map of CTRL at 0x000 and STATUS at 0x004.
 */
`timescale 1ns/1ps
module tb;
    import rbs_pkg::*;
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
    $display("BAD %s expected %0h seen %0h", n, e, g); end end
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, bit_valid = 0, run = 0, erise = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    rbs_bit_s bit_data = '0;
    logic hreadyout, hresp, bit_ready, clk_o, clk_oe, fs_o, fs_oe, payload, msync, crcsync;
    logic bp_clk, bp_sync, ser_clk, fsync, prod_on = 0;
    logic [7:0] pat;
    logic [2:0] smp[$];
    int miscompares = 0, checks_done = 0, seed = 93, idx = 0;
    assign ser_clk = clk_oe ? clk_o : bp_clk;
    assign fsync = fs_oe ? fs_o : bp_sync;
    always #2 hclk = ~hclk;

    rbs_top #(.DIV_HALF(4), .FIFO_DEPTH(8)) rbs_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .bit_valid(bit_valid), .bit_ready(bit_ready), .bit_data(bit_data),
        .rx_serial_clock_i(ser_clk), .rx_serial_clock_o(clk_o), .rx_serial_clock_oe(clk_oe),
        .rx_frame_sync_i(fsync), .rx_frame_sync_o(fs_o), .rx_frame_sync_oe(fs_oe),
        .rx_serial_payload(payload), .rx_multiframe_sync(msync), .rx_crc_multiframe_sync(crcsync));
    rbs_bp_partner rbs_bp_partner_inst (.run(run), .edge_rise(erise), .clk_o(bp_clk), .sync_o(bp_sync));

    // ----------------------------------------------------------------
    // Framer stream: 8-bit frames, markers on the first bit
    // ----------------------------------------------------------------
    always @(posedge hclk) begin
        if (!prod_on) idx = 0;
        else if (bit_valid && bit_ready) idx = (idx + 1) % 8;
        bit_valid <= prod_on;
        bit_data <= '{crc_mf_start: idx == 0, mf_start: idx == 0, frame_start: idx == 0, payload: pat[idx]};
    end
    always @(ser_clk) if (run && ser_clk === erise) smp.push_back({crcsync, msync, payload});

    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        hsize <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : bus

    function automatic logic [31:0] mkc(logic m, logic [1:0] r, logic s, logic er, logic e1, logic crc);
        rbs_ctrl_s c;
        c = '{crc_en: crc, e1: e1, edge_rise: er, slip_en: s, rate: rbs_rate_e'(r), mux_en: m};
        return {25'h0, c};
    endfunction : mkc

    task automatic stream(input logic e1, input logic crc, input logic er);
        int found, off;
        logic ok;
        found = 0;
        off = 0;
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b1, 32'h0, mkc(0, 0, 1, er, e1, crc), rd);
        erise = er;
        run = 1'b1;
        prod_on <= 1'b1;
        repeat (24 * 40) @(posedge hclk);
        smp.delete();
        repeat (24 * 40) @(posedge hclk);
        run = 1'b0;
        prod_on <= 1'b0;
        for (int o = 0; o < 8; o++) begin
            ok = 1'b1;
            foreach (smp[j]) if (smp[j][0] !== pat[(j + o) % 8]) ok = 1'b0;
            if (ok) begin found++; off = o; end
        end
        `CHK("payload order", 1, found)
        foreach (smp[j]) `CHK("sync and payload", {e1 && crc && (j + off) % 8 == 0, !e1 && (j + off) % 8 == 0,
            pat[(j + off) % 8]}, smp[j])
        bus(1'b0, 32'h4, 32'h0, rd);
        `CHK("slip and aligned", 2'b10, {rd[3], rd[1]})
        $display("test stream e1=%0d crc=%0d rise=%0d done", e1, crc, er);
    endtask : stream

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : final_report

    initial begin
        #200000;
        miscompares++;
        final_report();
    end

    initial begin
        int n, fsn;
        logic prev;
        do pat = 8'($random(seed)); while (pat == {pat[3:0], pat[7:4]});
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, 32'h0, 32'h0, rd);
        `CHK("ctrl reset", 32'h8, rd)
        bus(1'b0, 32'h100, 32'h0, rd);
        `CHK("unmapped", 32'h0, rd)
        `CHK("okay response", 1'b0, hresp)
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, 32'h0, mkc(0, 2'(m), 1, 0, 0, 0), rd);
            bus(1'b0, 32'h4, 32'h0, rd);
            `CHK("rate mirror", 2'(m), rd[9:8])
            `CHK("clock input", 1'b0, clk_oe)
        end
        bus(1'b1, 32'h0, mkc(0, 1, 0, 0, 0, 0), rd);
        repeat (4) @(posedge hclk);
        `CHK("mode 01 clock input", 1'b0, clk_oe)
        bus(1'b1, 32'h0, mkc(0, 0, 0, 0, 0, 0), rd);
        repeat (4) @(posedge hclk);
        `CHK("clock driven", 2'b11, {clk_oe, fs_oe})
        n = 0;
        fsn = 0;
        prev = clk_o;
        prod_on <= 1'b1;
        repeat (160) begin
            @(posedge hclk);
            #1;
            if (clk_o !== prev) n++;
            prev = clk_o;
            if (fs_o === 1'b1) begin
                fsn++;
                `CHK("frame sync bit", {1'b1, pat[0]}, {msync, payload})
            end
        end
        prod_on <= 1'b0;
        `CHK("clock toggles", 1'b1, n >= 39 && n <= 41)
        `CHK("frame sync seen", 1'b1, fsn > 0)
        bus(1'b1, 32'h0, mkc(1, 0, 0, 0, 0, 0), rd);
        repeat (4) @(posedge hclk);
        `CHK("mux idle", 5'h0, {clk_oe, fs_oe, payload, msync, crcsync})
        $display("test modes done");
        stream(1'b0, 1'b0, 1'b0);
        stream(1'b1, 1'b1, 1'b1);
        stream(1'b1, 1'b0, 1'b0);
        final_report();
    end
endmodule : tb
